/* File: qed_sync.sv */
// Purpose: Shared constants and the three-stage pin synchroniser for the quadrature decoder
// Assumes: Pins are asynchronous to clk_sys; rst_n is already synchronous to clk_sys
// Notes:   A bit's output changes once stages two and three agree
`timescale 1ns/100ps
package qed_pkg;
   localparam int SYNC_STAGES        = 3;
   localparam int FILL_CYCLES        = 4;
   localparam int CLK_PERIOD_NS      = 25;
   localparam int CYCLE_FREQ_MAX_KHZ = 100;
   localparam int CYCLE_MIN_NS       = 1000000 / CYCLE_FREQ_MAX_KHZ;
   localparam int DEG_PER_CYCLE      = 360;
   localparam int STATES_PER_CYCLE   = 4;
   localparam int STATE_NOM_DEG      = 90;
   localparam int STATE_ERR_MAX_DEG  = 40;
   localparam int CPR_DEFAULT        = 500;
   localparam int CPR_MIN            = 96;
   localparam int CPR_MAX            = 1000;
   localparam int POS_W_DEFAULT      = 32;
   localparam int WID_W              = 8;
   // Shortest legal state at top speed, rounded up to whole clocks
   localparam int STATE_MIN_CYC      = (CYCLE_MIN_NS * (STATE_NOM_DEG - STATE_ERR_MAX_DEG)
                                        + DEG_PER_CYCLE * CLK_PERIOD_NS - 1)
                                       / (DEG_PER_CYCLE * CLK_PERIOD_NS);
   localparam int ANG_W              = $clog2(STATES_PER_CYCLE * CPR_MAX);
   localparam logic [1:0] AB_RST     = 2'h0;
   typedef enum logic [0:0] {QED_WAIT, QED_RUN} qed_state_t;
endpackage

module qed_sync #(
   parameter int W = 2
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic              vld
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [2:0]   fill_r;
   logic [2:0]   fill_nxt;

   if (W < 1) begin : g_chk
      $error("qed_sync: W must be at least 1");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      logic q_nxt;
      assign q_nxt = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            s1_r[i] <= 1'b0;
            s2_r[i] <= 1'b0;
            s3_r[i] <= 1'b0;
            q_r[i]  <= 1'b0;
         end else begin
            s1_r[i] <= d[i];
            s2_r[i] <= s1_r[i];
            s3_r[i] <= s2_r[i];
            q_r[i]  <= q_nxt;
         end
      end
   end

   assign fill_nxt = (fill_r == 3'(qed_pkg::FILL_CYCLES)) ? fill_r : fill_r + 3'h1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fill_r <= 3'h0;
      end else begin
         fill_r <= fill_nxt;
      end
   end

   assign q   = q_r;
   assign vld = (fill_r == 3'(qed_pkg::FILL_CYCLES));

   chk_sync_agree: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
      (s2_r == s3_r) |=> (q_r == $past(s3_r)))
      else $error("synchroniser output ignored agreeing stages");
endmodule // qed_sync

/* File: qed_decoder.sv */
// Purpose: Host decoder for a two-channel quadrature encoder: position, direction, angle, faults
// Assumes: chan_a and chan_b come straight from the encoder pins, asynchronous to clk_sys
// Notes:   Notes on behaviour follow
// Notes on behaviour
// R1: The encoder drives exactly two outputs, the second a quarter cycle behind the first.
// R2: Each cycle has four states bounded by alternating transitions on the two channels.
// R3: Each encoder output is high for about half a cycle, within 40 degrees of error.
// R4: Channel A leading means forward and B leading means reverse; direction follows the leader.
// R5: States may deviate by up to 40 degrees from a quarter cycle and must still decode.
// R6: The spacing between the high centres of the two channels is about 90 degrees.
// R7: One shaft turn gives N cycles, so 4N states are counted per turn.
// R8: The codewheel count may be 500 or 1000, or anywhere from 96 to 512.
// R9: Cycles run up to 100 kHz and sampling must resolve every state at that rate.
// R10: Both channels pass a synchroniser and each single-channel change steps the count by one.
// R11: A change on both channels at once is illegal, leaves the count alone and sets a sticky flag.
`timescale 1ns/100ps
module qed_decoder #(
   parameter int CPR   = qed_pkg::CPR_DEFAULT,
   parameter int POS_W = qed_pkg::POS_W_DEFAULT
) (
   input  wire logic                       clk_sys,
   input  wire logic                       arst_n,
   input  wire logic                       chan_a,
   input  wire logic                       chan_b,
   input  wire logic                       pos_clr,
   input  wire logic                       err_clr,
   output logic signed [POS_W-1:0]         pos_count,
   output logic [qed_pkg::ANG_W-1:0]       angle,
   output logic                            dir_fwd,
   output logic                            step_pulse,
   output logic                            rev_pulse,
   output logic                            illegal_err,
   output logic                            overspeed_err
);
   localparam int ANG_W   = qed_pkg::ANG_W;
   localparam int ANG_TOP = qed_pkg::STATES_PER_CYCLE * CPR - 1;

   // Elaboration checks
   if (CPR < qed_pkg::CPR_MIN || CPR > qed_pkg::CPR_MAX) begin : g_chk_cpr // [R8]
      $error("qed_decoder: CPR out of supported range");
   end
   if (POS_W < 2 || POS_W > 64) begin : g_chk_pos
      $error("qed_decoder: POS_W out of range");
   end
   if (qed_pkg::STATE_MIN_CYC <= qed_pkg::FILL_CYCLES) begin : g_chk_rate // [R9]
      $error("qed_decoder: clock too slow to resolve every state");
   end

   logic                     rst_s1_r;
   logic                     rst_n_s;
   logic [1:0]               ab_cur;
   logic                     sync_vld;
   logic [1:0]               ab_prev_r;
   qed_pkg::qed_state_t      st_r;
   qed_pkg::qed_state_t      st_nxt;
   logic signed [POS_W-1:0]  pos_r;
   logic signed [POS_W-1:0]  pos_nxt;
   logic [ANG_W-1:0]         ang_r;
   logic [ANG_W-1:0]         ang_nxt;
   logic [qed_pkg::WID_W-1:0] wid_r;
   logic [qed_pkg::WID_W-1:0] wid_nxt;
   logic                     dir_r;
   logic                     step_r;
   logic                     rev_r;
   logic                     ill_r;
   logic                     ovs_r;

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_s  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_s  <= rst_s1_r;
      end
   end

   qed_sync #(
      .W       (2)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_s),
      .d       ({chan_a, chan_b}),
      .q       (ab_cur),
      .vld     (sync_vld)
   ); // [R10]

   // Transition decode; ab[1] is A, ab[0] is B
   logic       running;
   logic [1:0] chg;
   logic       one_chg;
   logic       both_chg;
   logic       fwd;
   logic       step_fwd;
   logic       step_rev;
   logic       ang_wrap_f;
   logic       ang_wrap_r;
   logic       too_fast;

   assign running    = (st_r == qed_pkg::QED_RUN);
   assign chg        = ab_cur ^ ab_prev_r;
   assign one_chg    = running && (chg[1] ^ chg[0]);          // [R2]
   assign both_chg   = running && chg[1] && chg[0];           // [R11]
   assign fwd        = ab_prev_r[0] ^ ab_cur[1];              // [R4]
   assign step_fwd   = one_chg && fwd;
   assign step_rev   = one_chg && !fwd;
   assign ang_wrap_f = step_fwd && (ang_r == ANG_W'(ANG_TOP)); // [R7]
   assign ang_wrap_r = step_rev && (ang_r == '0);
   assign too_fast   = one_chg && (wid_r < qed_pkg::WID_W'(qed_pkg::STATE_MIN_CYC - 1)); // [R5] [R9]

   // Position follows direction; illegal steps leave it alone
   assign pos_nxt = pos_clr  ? '0 :
                    step_fwd ? pos_r + POS_W'(1) :                       // [R10]
                    step_rev ? pos_r - POS_W'(1) : pos_r;                // [R11]

   // Angle within one turn, 4N states
   assign ang_nxt = pos_clr    ? '0 :
                    ang_wrap_f ? '0 :
                    ang_wrap_r ? ANG_W'(ANG_TOP) :
                    step_fwd   ? ang_r + ANG_W'(1) :
                    step_rev   ? ang_r - ANG_W'(1) : ang_r;             // [R7]

   // Clocks since last accepted state change, saturating
   assign wid_nxt = one_chg ? '0 :
                    (wid_r == '1) ? wid_r : wid_r + qed_pkg::WID_W'(1);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         qed_pkg::QED_WAIT: begin
            if (sync_vld) begin
               st_nxt = qed_pkg::QED_RUN;
            end
         end
         qed_pkg::QED_RUN: begin
            st_nxt = qed_pkg::QED_RUN;
         end
         default: begin
            st_nxt = qed_pkg::QED_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         st_r      <= qed_pkg::QED_WAIT;
         ab_prev_r <= qed_pkg::AB_RST;
      end else begin
         st_r      <= st_nxt;
         ab_prev_r <= ab_cur;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pos_r <= '0;
         ang_r <= '0;
         wid_r <= '1;
      end else begin
         pos_r <= pos_nxt;
         ang_r <= ang_nxt;
         wid_r <= wid_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         dir_r  <= 1'b1;
         step_r <= 1'b0;
         rev_r  <= 1'b0;
      end else begin
         dir_r  <= one_chg ? fwd : dir_r;                     // [R4]
         step_r <= one_chg;
         rev_r  <= ang_wrap_f || ang_wrap_r;                  // [R7]
      end
   end

   // Sticky faults; a new event wins over a clear
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ill_r <= 1'b0;
         ovs_r <= 1'b0;
      end else begin
         ill_r <= both_chg || (ill_r && !err_clr);            // [R11]
         ovs_r <= too_fast || (ovs_r && !err_clr);            // [R9]
      end
   end

   assign pos_count     = pos_r;
   assign angle         = ang_r;
   assign dir_fwd       = dir_r;
   assign step_pulse    = step_r;
   assign rev_pulse     = rev_r;
   assign illegal_err   = ill_r;
   assign overspeed_err = ovs_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_s);

   chk_fwd_count: assert property (step_fwd && !pos_clr |=> pos_r == $past(pos_r) + POS_W'(1)) // [R10]
      else $error("forward step did not increment position");
   chk_rev_count: assert property (step_rev && !pos_clr |=> pos_r == $past(pos_r) - POS_W'(1)) // [R4]
      else $error("reverse step did not decrement position");
   chk_illegal_hold: assert property (both_chg && !pos_clr |=> $stable(pos_r) && ill_r) // [R11]
      else $error("double change altered position or missed flag");
   chk_err_sticky: assert property (ill_r && !err_clr |=> ill_r [*2] or (ill_r ##1 !ill_r)) // [R11]
      else $error("illegal flag dropped without clear");
   chk_turn_wrap: assert property (ang_wrap_f && !pos_clr |=> ang_r == '0 && rev_pulse) // [R7]
      else $error("angle did not wrap after 4N states");
   chk_dir_track: assert property (one_chg |=> dir_fwd == $past(fwd) ##1 1'b1) // [R4]
      else $error("direction does not follow leading channel");
   chk_step_pos: assert property (!pos_clr && !$past(pos_clr) && $changed(pos_r) |-> $past(one_chg)) // [R2]
      else $error("position moved without a single-channel change");
   chk_state_speed: assert property (too_fast |=> overspeed_err) // [R5]
      else $error("short state not flagged");
   chk_set_wins: assert property (both_chg && err_clr |=> ill_r) // [R11]
      else $error("clear beat a simultaneous illegal event");

   cov_fwd_step: cover property (step_fwd);
   cov_rev_step: cover property (step_rev);
   cov_illegal: cover property (both_chg);
   cov_turn: cover property (rev_pulse);
endmodule // qed_decoder

/* File: qed_enc_model.sv */
// Purpose: Behavioural encoder with two quadrature outputs, stepped on request
// Assumes: The bench sets each state width by how far apart it spaces its requests
// Notes:   The real part has no clock; clk_sys only times this model
`timescale 1ns/100ps
module qed_enc_model (
   input  wire logic clk_sys,
   input  wire logic step_req,
   input  wire logic fwd,
   input  wire logic jump,
   output logic      chan_a,
   output logic      chan_b
);
   logic [1:0] phase_r = 2'h0;
   // Gray order 00,10,11,01: A leads B going forward
   assign chan_a = phase_r[0] ^ phase_r[1];
   assign chan_b = phase_r[1];
   // Jump moves both outputs at once
   always @(posedge clk_sys) begin
      if (jump) begin
         phase_r <= phase_r + 2'h2;
      end else if (step_req) begin
         phase_r <= fwd ? phase_r + 2'h1 : phase_r - 2'h1;
      end
   end
endmodule // qed_enc_model

/* File: quadrature_encoder_interface_bench.sv */
// Purpose: Self-checking bench for the quadrature decoder
// Assumes: Decoder built for 96 cycles per turn
// Notes:   State widths of 60 clocks or more are legal at top speed
`timescale 1ns/100ps
module quadrature_encoder_interface_bench;
   localparam int CPR  = 96;
   localparam int TURN = 4 * CPR;
   localparam int W_OK = 60;
   logic                        clk_sys  = 1'b0;
   logic                        arst_n   = 1'b0;
   logic                        pos_clr  = 1'b0;
   logic                        err_clr  = 1'b0;
   logic                        step_req = 1'b0;
   logic                        fwd      = 1'b1;
   logic                        jump     = 1'b0;
   logic                        chan_a;
   logic                        chan_b;
   logic signed [31:0]          pos_count;
   logic [qed_pkg::ANG_W-1:0]   angle;
   logic                        dir_fwd;
   logic                        step_pulse;
   logic                        rev_pulse;
   logic                        illegal_err;
   logic                        overspeed_err;
   int                          n_errors = 0;
   int                          samples_checked = 0;
   int                          n_step = 0;
   int                          n_rev = 0;

   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (step_pulse === 1'b1) n_step++;
      if (rev_pulse === 1'b1) n_rev++;
   end

   qed_enc_model u_enc (.clk_sys(clk_sys), .step_req(step_req), .fwd(fwd), .jump(jump),
                        .chan_a(chan_a), .chan_b(chan_b));
   qed_decoder #(.CPR(CPR), .POS_W(32)) u_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .chan_a(chan_a), .chan_b(chan_b),
      .pos_clr(pos_clr), .err_clr(err_clr), .pos_count(pos_count), .angle(angle),
      .dir_fwd(dir_fwd), .step_pulse(step_pulse), .rev_pulse(rev_pulse),
      .illegal_err(illegal_err), .overspeed_err(overspeed_err));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic step(input logic f, input logic j, input int w);
      fwd = f;
      jump = j;
      step_req = ~j;
      tick(1);
      step_req = 1'b0;
      jump = 1'b0;
      tick(w - 1);
   endtask
   task automatic pulse_clr(input logic p, input logic e);
      pos_clr = p;
      err_clr = e;
      tick(1);
      pos_clr = 1'b0;
      err_clr = 1'b0;
      tick(1);
   endtask

   task automatic t_reset;
      chk("dir_fwd", 32'(dir_fwd), 32'h1);
      chk("pos_count", pos_count, 32'h0);
      chk("illegal_err", 32'(illegal_err), 32'h0);
      arst_n = 1'b1;
      tick(12);
      chk("pos_count", pos_count, 32'h0);
      chk("step count", n_step, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_forward;
      int i;
      step(1'b1, 1'b0, 1);
      for (i = 0; i < 12 && step_pulse !== 1'b1; i++) tick(1);
      chk("step_pulse", 32'(step_pulse), 32'h1);
      if (step_pulse !== 1'b1) begin
         conclude();
      end
      tick(W_OK);
      // Uneven states, all above the top-speed minimum
      for (i = 1; i < 8; i++) step(1'b1, 1'b0, (i % 2) ? W_OK : 2 * W_OK);
      chk("pos_count", pos_count, 32'h8);
      chk("angle", 32'(angle), 32'h8);
      chk("step count", n_step, 32'h8);
      chk("dir_fwd", 32'(dir_fwd), 32'h1);
      chk("overspeed_err", 32'(overspeed_err), 32'h0);
      $display("test forward done");
   endtask
   task automatic t_reverse;
      n_rev = 0;
      repeat (12) step(1'b0, 1'b0, W_OK);
      chk("pos_count", pos_count, -32'sd4);
      chk("dir_fwd", 32'(dir_fwd), 32'h0);
      chk("angle", 32'(angle), TURN - 4);
      chk("rev_pulse count", n_rev, 32'h1);
      $display("test reverse done");
   endtask
   task automatic t_turn;
      pulse_clr(1'b1, 1'b0);
      chk("pos_count", pos_count, 32'h0);
      chk("angle", 32'(angle), 32'h0);
      n_rev = 0;
      repeat (TURN) step(1'b1, 1'b0, W_OK);
      chk("pos_count", pos_count, TURN);
      chk("angle", 32'(angle), 32'h0);
      chk("rev_pulse count", n_rev, 32'h1);
      $display("test turn done");
   endtask
   task automatic t_faults;
      step(1'b1, 1'b1, W_OK);
      chk("illegal_err", 32'(illegal_err), 32'h1);
      chk("pos_count", pos_count, TURN);
      pulse_clr(1'b0, 1'b1);
      chk("illegal_err", 32'(illegal_err), 32'h0);
      step(1'b1, 1'b0, 30);
      step(1'b1, 1'b0, W_OK);
      chk("overspeed_err", 32'(overspeed_err), 32'h1);
      chk("pos_count", pos_count, TURN + 2);
      pulse_clr(1'b0, 1'b1);
      chk("overspeed_err", 32'(overspeed_err), 32'h0);
      // Clear lands on the edge that sees a new double change
      jump = 1'b1;
      tick(1);
      jump = 1'b0;
      tick(4);
      err_clr = 1'b1;
      tick(1);
      err_clr = 1'b0;
      tick(W_OK);
      chk("illegal_err", 32'(illegal_err), 32'h1);
      chk("pos_count", pos_count, TURN + 2);
      $display("test faults done");
   endtask

   initial begin
      tick(16);
      t_reset();
      t_forward();
      t_reverse();
      t_turn();
      t_faults();
      conclude();
   end
endmodule // quadrature_encoder_interface_bench
